/* hw/ref_ctrl_pkg.sv */
/*
  Constants, register map and carrier types for the reference sample and lock control.
  Assumes a byte-wide register port and a 100 MHz clock; the slow oscillator arrives as a level input.
*/
package ref_ctrl_pkg;
  localparam logic [1:0] ADDR_CAL_NOMINAL = 2'h0;
  localparam logic [1:0] ADDR_CAL_LINEAR = 2'h1;
  localparam logic [1:0] ADDR_SAMPLE_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_LOCK = 2'h3;
  localparam int LOCK_ENABLE_POS = 1;
  localparam int LOCK_BIT_POS = 0;
  localparam logic [7:0] CAL_RESET = 8'h00;
  localparam logic [2:0] SAMPLE_CONFIG_RESET = 3'h0;
  localparam logic [2:0] CODE_CONTINUOUS = 3'h0;
  localparam logic [2:0] CODE_OFF = 3'h7;
  localparam int CLK_MHZ = 100;
  localparam int GUARD_SLOW_CYCLES = 3;
  localparam int GUARD_CPU_CYCLES = 3;
  localparam int LOCK_WINDOW_CYCLES = 4;
  // slow oscillator periods in 1 ms; plain default
  localparam int SLOW_PER_MS = 32;
  localparam int ON_PULSE_SLOW_CYCLES = 2;
  localparam int OFF_COUNT_WIDTH = 11;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_s;

  typedef struct packed {
    logic coreEnable;
    logic bufferEnable;
  } ref_enable_s;
endpackage

/* hw/ref_sample_lock_ctrl.sv */
/*
  Reference sample-mode sequencer, calibration registers and lock sequence.
  Assumes slowOsc is a free-running level synchronous-enough to sample with two flops,
  powerDownSleep is high only in power-down sleep, and porReset is the power-on reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ref_sample_lock_ctrl (
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic porReset,
  // factory trim values
  input wire logic [7:0] factoryNominal,
  input wire logic [7:0] factoryLinear,
  // register port
  input wire ref_ctrl_pkg::reg_req_s regReq,
  output logic [7:0] rdata,
  // power state and slow oscillator
  input wire logic powerDownSleep,
  input wire logic slowOsc,
  // analog enables and status
  output ref_ctrl_pkg::ref_enable_s refEnable,
  output logic guardBusy,
  output logic locked
);
  typedef enum logic [2:0] {
    ST_ON = 3'b001,
    ST_PULSE = 3'b010,
    ST_OFF = 3'b100
  } sample_state_e;

  localparam int OFF_WIDTH = ref_ctrl_pkg::OFF_COUNT_WIDTH;

  function automatic logic [OFF_WIDTH-1:0] offCount(input logic [2:0] code);
    offCount = OFF_WIDTH'(ref_ctrl_pkg::SLOW_PER_MS) << (code - 3'h1);
  endfunction

  logic [7:0] nominalTrim;
  logic [7:0] linearTrim;
  logic [2:0] sampleConfig;
  logic lockEnable;
  logic lockBit;
  logic [2:0] lockWindow;
  logic [1:0] guardSlow;
  logic [1:0] guardCpu;
  logic slowMeta;
  logic slowSync;
  logic slowPrev;
  logic slowTick;
  logic [OFF_WIDTH-1:0] offCounter;
  sample_state_e state;
  logic wrNominal;
  logic wrLinear;
  logic wrControl;
  logic wrLock;
  logic writeOk;

  assign writeOk = regReq.write && !locked;
  assign wrNominal = writeOk && regReq.addr == ref_ctrl_pkg::ADDR_CAL_NOMINAL;
  assign wrLinear = writeOk && regReq.addr == ref_ctrl_pkg::ADDR_CAL_LINEAR;
  // a write during the guard period is dropped, not queued
  assign wrControl = writeOk && !guardBusy && regReq.addr == ref_ctrl_pkg::ADDR_SAMPLE_CONTROL;
  assign wrLock = regReq.write && regReq.addr == ref_ctrl_pkg::ADDR_LOCK;
  assign slowTick = slowSync && !slowPrev;

  // trims do not survive chip reset; only power-on clears, chip reset reloads factory values
  always_ff @(posedge clk) begin
    if (porReset) begin
      nominalTrim <= ref_ctrl_pkg::CAL_RESET;
      linearTrim <= ref_ctrl_pkg::CAL_RESET;
    end else if (reset) begin
      nominalTrim <= factoryNominal;
      linearTrim <= factoryLinear;
    end else begin
      if (wrNominal) begin
        nominalTrim <= regReq.wdata;
      end
      if (wrLinear) begin
        linearTrim <= regReq.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sampleConfig <= ref_ctrl_pkg::SAMPLE_CONFIG_RESET;
    end else if (wrControl) begin
      sampleConfig <= regReq.wdata[2:0];
    end
  end

  // guard: three slow edges, then three cpu cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      guardSlow <= 2'h0;
      guardCpu <= 2'h0;
      guardBusy <= 1'b0;
    end else if (wrControl) begin
      guardSlow <= 2'(ref_ctrl_pkg::GUARD_SLOW_CYCLES);
      guardCpu <= 2'(ref_ctrl_pkg::GUARD_CPU_CYCLES);
      guardBusy <= 1'b1;
    end else if (guardSlow != 2'h0) begin
      if (slowTick) begin
        guardSlow <= guardSlow - 2'h1;
      end
    end else if (guardCpu != 2'h0) begin
      guardCpu <= guardCpu - 2'h1;
      guardBusy <= guardCpu != 2'h1;
    end
  end

  // lock sequence; both bits read back as last written while unlocked
  always_ff @(posedge clk) begin
    if (reset) begin
      lockEnable <= 1'b0;
      lockBit <= 1'b0;
      lockWindow <= 3'h0;
      locked <= 1'b0;
    end else begin
      if (lockWindow != 3'h0) begin
        lockWindow <= lockWindow - 3'h1;
      end
      if (wrLock && !locked) begin
        lockEnable <= regReq.wdata[ref_ctrl_pkg::LOCK_ENABLE_POS];
        lockBit <= regReq.wdata[ref_ctrl_pkg::LOCK_BIT_POS];
        if (regReq.wdata[1:0] == 2'b11) begin
          lockWindow <= 3'(ref_ctrl_pkg::LOCK_WINDOW_CYCLES);
        end else if (regReq.wdata[1:0] == 2'b01 && lockWindow != 3'h0) begin
          locked <= 1'b1;
          lockWindow <= 3'h0;
        end else begin
          lockWindow <= 3'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slowMeta <= 1'b0;
      slowSync <= 1'b0;
      slowPrev <= 1'b0;
    end else begin
      slowMeta <= slowOsc;
      slowSync <= slowMeta;
      slowPrev <= slowSync;
    end
  end

  // sequencer; leaving power-down returns straight to continuous
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_ON;
      offCounter <= '0;
    end else if (!powerDownSleep || sampleConfig == ref_ctrl_pkg::CODE_CONTINUOUS) begin
      state <= ST_ON;
      offCounter <= '0;
    end else if (sampleConfig == ref_ctrl_pkg::CODE_OFF) begin
      state <= ST_OFF;
      offCounter <= '0;
    end else begin
      case (state)
        ST_ON: begin
          state <= ST_OFF;
          offCounter <= offCount(sampleConfig);
        end
        ST_OFF: begin
          if (slowTick) begin
            if (offCounter <= OFF_WIDTH'(1)) begin
              state <= ST_PULSE;
              offCounter <= OFF_WIDTH'(ref_ctrl_pkg::ON_PULSE_SLOW_CYCLES);
            end else begin
              offCounter <= offCounter - OFF_WIDTH'(1);
            end
          end
        end
        ST_PULSE: begin
          if (slowTick) begin
            if (offCounter <= OFF_WIDTH'(1)) begin
              state <= ST_OFF;
              offCounter <= offCount(sampleConfig);
            end else begin
              offCounter <= offCounter - OFF_WIDTH'(1);
            end
          end
        end
        default: begin
          state <= ST_ON;
          offCounter <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      refEnable <= '{coreEnable: 1'b1, bufferEnable: 1'b1};
    end else begin
      refEnable.coreEnable <= state != ST_OFF;
      refEnable.bufferEnable <= state != ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (regReq.read) begin
      case (regReq.addr)
        ref_ctrl_pkg::ADDR_CAL_NOMINAL: rdata <= nominalTrim;
        ref_ctrl_pkg::ADDR_CAL_LINEAR: rdata <= linearTrim;
        ref_ctrl_pkg::ADDR_SAMPLE_CONTROL: rdata <= {5'h00, sampleConfig};
        ref_ctrl_pkg::ADDR_LOCK: rdata <= {6'h00, lockEnable, lockBit};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* testbench/ref_ctrl_checker.sv */
/* assertions for the reference sample and lock control
   bound into ref_sample_lock_ctrl; sees its ports only */
`timescale 1ns/100ps
`default_nettype none
module ref_ctrl_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire ref_ctrl_pkg::reg_req_s regReq,
  input wire logic [7:0] rdata,
  // power and status
  input wire logic powerDownSleep,
  input wire ref_ctrl_pkg::ref_enable_s refEnable,
  input wire logic guardBusy,
  input wire logic locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_awake_on: assert property (!powerDownSleep [*3] |-> refEnable == 2'b11)
    else $error("enables low while awake");
  a_core_buffer: assert property (refEnable.coreEnable == refEnable.bufferEnable)
    else $error("core and buffer differ");
  a_rdata_idle: assert property (!$past(regReq.read) |-> rdata == 8'h00)
    else $error("read data without read");
  a_ctrl_upper: assert property ($past(regReq.read && regReq.addr == 2'h2) |-> rdata[7:3] == 5'h00)
    else $error("control upper bits set");
  a_lock_upper: assert property ($past(regReq.read && regReq.addr == 2'h3) |-> rdata[7:2] == 6'h00)
    else $error("lock upper bits set");
  a_lock_stays: assert property (locked |=> locked)
    else $error("lock dropped");
  a_lock_cause: assert property ($rose(locked) |-> $past(regReq.write && regReq.addr == 2'h3 && regReq.wdata[1:0] == 2'b01))
    else $error("lock without second write");
  a_guard_set: assert property (regReq.write && regReq.addr == 2'h2 && !guardBusy && !locked |=> guardBusy)
    else $error("guard not started");
  a_guard_min: assert property ($rose(guardBusy) |-> guardBusy [*6])
    else $error("guard too short");
  c_locked: cover property ($rose(locked));
  c_guard_done: cover property ($fell(guardBusy));
  c_sampled_off: cover property ($fell(refEnable.coreEnable));
endmodule
bind ref_sample_lock_ctrl ref_ctrl_checker chk_u (.clk(clk), .reset(reset), .regReq(regReq), .rdata(rdata),
  .powerDownSleep(powerDownSleep), .refEnable(refEnable), .guardBusy(guardBusy), .locked(locked));
`default_nettype wire

/* testbench/testbench.sv */
/* self-checking bench for ref_sample_lock_ctrl
   drives every port itself; slow oscillator runs at a quarter of clk */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, reset = 1, porReset = 1, powerDown = 0, slowOsc = 0;
  logic [1:0] slowCnt = 0;
  ref_ctrl_pkg::reg_req_s regReq = '0;
  ref_ctrl_pkg::ref_enable_s refEnable;
  logic [7:0] rdata;
  logic guardBusy, locked;
  int errCount = 0, checkCount = 0, cyc = 0, n;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    slowCnt <= slowCnt + 2'h1;
    slowOsc <= slowCnt[1];
  end
  ref_sample_lock_ctrl dut_u (.clk(clk), .reset(reset), .porReset(porReset), .factoryNominal(8'h5a),
    .factoryLinear(8'hc3), .regReq(regReq), .rdata(rdata), .powerDownSleep(powerDown), .slowOsc(slowOsc),
    .refEnable(refEnable), .guardBusy(guardBusy), .locked(locked));
  task automatic chk(input string s, input logic [15:0] e, g);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) regReq.write <= 1'b0;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string s);
    @(posedge clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) regReq.read <= 1'b0;
    #1 chk(s, e, rdata);
  endtask
  // bounded wait on guard (g) or core enable until it equals v; n holds the cycles
  task automatic waits(input bit g, input logic v);
    n = 0;
    while ((g ? guardBusy : refEnable.coreEnable) !== v && n < 9000) begin
      @(posedge clk) #1;
      n++;
    end
  endtask
  task automatic pulse;
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic finishTest;
    if (errCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tCal;
    rdc(2'h0, 8'h00, "nominal por");
    rdc(2'h1, 8'h00, "linear por");
    wr(2'h0, 8'h3c);
    rdc(2'h0, 8'h3c, "nominal rw");
    pulse;
    rdc(2'h0, 8'h5a, "nominal load");
    rdc(2'h1, 8'hc3, "linear load");
    wr(2'h3, 8'hfc);
    rdc(2'h3, 8'h00, "lock upper");
  endtask
  task automatic tGuard;
    wr(2'h2, 8'hf9);
    #1 chk("guard", 1, guardBusy);
    wr(2'h2, 8'h03);
    waits(1'b1, 1'b0);
    rdc(2'h2, 8'h01, "guard ignore");
  endtask
  task automatic tSample;
    for (int c = 0; c < 8; c++) begin
      wr(2'h2, 8'(c)); // code 7 only with brownout detector off
      waits(1'b1, 1'b0);
      @(posedge clk) powerDown <= 1'b1;
      if (c == 0 || c == 7) begin
        repeat (300) @(posedge clk);
        #1 chk("fixed", 16'(c == 0), refEnable.coreEnable);
      end else begin
        waits(1'b0, 1'b0);
        waits(1'b0, 1'b1);
        waits(1'b0, 1'b0);
        chk("on time", 8, 16'(n));
        waits(1'b0, 1'b1);
        chk("off time", 16'(128 << (c - 1)), 16'(n));
      end
      @(posedge clk) powerDown <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("wake", 1, refEnable.coreEnable);
    end
  endtask
  task automatic tLock;
    wr(2'h3, 8'h03);
    wr(2'h3, 8'h02);
    wr(2'h3, 8'h01);
    #1 chk("lock wrong", 0, locked);
    wr(2'h3, 8'h03);
    repeat (3) @(posedge clk);
    wr(2'h3, 8'h01);
    #1 chk("lock late", 0, locked);
    wr(2'h3, 8'h03);
    repeat (2) @(posedge clk);
    wr(2'h3, 8'h01);
    #1 chk("lock", 1, locked);
    wr(2'h0, 8'h11);
    wr(2'h2, 8'h05);
    wr(2'h3, 8'h00);
    rdc(2'h0, 8'h5a, "locked nominal");
    rdc(2'h2, 8'h07, "locked control");
    pulse;
    #1 chk("unlock", 0, locked);
    wr(2'h0, 8'h11);
    rdc(2'h0, 8'h11, "after unlock");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errCount++;
      finishTest;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    porReset <= 1'b0;
    tCal;
    tGuard;
    tSample;
    tLock;
    finishTest;
  end
endmodule
`default_nettype wire
